/* rtl/ebt_regs.svh */
`ifndef EBT_REGS_SVH
`define EBT_REGS_SVH
// ****************************************
// register map
// ****************************************
`define EBT_TIMING_ADDR 8'hEE
`define EBT_TIMING_PAGE 4'hF
`define EBT_TIMING_RESET 8'hFF
`define EBT_SETUP_MSB 7
`define EBT_SETUP_LSB 6
`define EBT_WIDTH_MSB 5
`define EBT_WIDTH_LSB 2
`define EBT_HOLD_MSB 1
`define EBT_HOLD_LSB 0
// ****************************************
// timing
// ****************************************
`define EBT_OVERHEAD_CYCLES 3'h4
`endif

/* rtl/ebt_pkg.sv */
package ebt_pkg;
  typedef enum logic [2:0] {
    EBT_IDLE = 3'b000,
    EBT_ALEH = 3'b001,
    EBT_ALEL = 3'b010,
    EBT_SETUP = 3'b011,
    EBT_STROBE = 3'b100,
    EBT_HOLD = 3'b101,
    EBT_TAIL = 3'b110
  } ebt_state_t;
  typedef logic [2:0] ebt_mode_t;
endpackage

/* rtl/ebt_ext_bus.sv */
`timescale 1ns/1ps
`include "ebt_regs.svh"
module ebt_ext_bus (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // special function register port
  input wire logic [7:0] sfrAddr,
  input wire logic [3:0] sfrPage,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  output logic sfrHit,
  // configuration from neighbouring registers
  input wire ebt_pkg::ebt_mode_t bus_muxing_select,
  input wire logic [1:0] aleWidth,
  input wire logic [7:0] upper_addr_bank,
  // transfer request
  input wire logic xferReq,
  input wire logic xferWrite,
  input wire logic xferWide,
  input wire logic [15:0] xferAddr,
  input wire logic [7:0] xferWdata,
  output logic xferBusy,
  output logic xferDone,
  output logic [7:0] xferRdata,
  // port 3, 4, 5 pins, enables low while driving
  output logic [7:0] p3Out,
  output logic p3OeN,
  output logic [7:0] p4Out,
  output logic p4OeN,
  input wire logic [7:0] p5In,
  output logic [7:0] p5Out,
  output logic p5OeN,
  // port 6 strobes
  output logic rdN,
  output logic wrN,
  output logic ale
);
  import ebt_pkg::*;

  // ****************************************
  // timing register
  // ****************************************
  logic [7:0] timing, next_timing;
  logic regSel;
  assign regSel = (sfrAddr == `EBT_TIMING_ADDR) && (sfrPage == `EBT_TIMING_PAGE);
  assign sfrHit = regSel;
  assign sfrRdata = regSel ? timing : 8'h00;

  always_comb begin
    next_timing = timing;
    if (regSel && sfrWrite) begin
      next_timing = sfrWdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timing <= `EBT_TIMING_RESET;
    end else if (clkEn) begin
      timing <= next_timing;
    end
  end

  logic [1:0] setupCode;
  logic [3:0] widthCode;
  logic [1:0] holdCode;
  assign setupCode = timing[`EBT_SETUP_MSB:`EBT_SETUP_LSB];
  assign widthCode = timing[`EBT_WIDTH_MSB:`EBT_WIDTH_LSB];
  assign holdCode = timing[`EBT_HOLD_MSB:`EBT_HOLD_LSB];

  // ****************************************
  // transfer sequencer
  // ****************************************
  ebt_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic muxed, next_muxed, isWrite, next_isWrite, drvHigh, next_drvHigh;
  logic [15:0] addr, next_addr;
  logic [7:0] wdata, next_wdata, rdata, next_rdata;
  logic done, next_done;
  logic modeMux, modeBank, modeNoBank, modeOk;

  assign modeMux = bus_muxing_select inside {3'b001, 3'b010, 3'b011};
  assign modeBank = bus_muxing_select inside {3'b010, 3'b110};
  assign modeNoBank = bus_muxing_select inside {3'b001, 3'b011, 3'b101, 3'b111};
  assign modeOk = modeBank || modeNoBank;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_muxed = muxed;
    next_isWrite = isWrite;
    next_drvHigh = drvHigh;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_done = 1'b0;
    case (state)
      EBT_IDLE: begin
        if (xferReq && modeOk) begin
          next_muxed = modeMux;
          next_isWrite = xferWrite;
          next_wdata = xferWdata;
          next_drvHigh = xferWide || modeBank;
          next_addr = xferWide ? xferAddr : {upper_addr_bank, xferAddr[7:0]};
          next_cnt = {2'b00, aleWidth};
          if (modeMux) begin
            next_state = EBT_ALEH;
          end else if (setupCode == 2'b00) begin
            next_cnt = widthCode;
            next_state = EBT_STROBE;
          end else begin
            next_cnt = {2'b00, setupCode} - 4'h1;
            next_state = EBT_SETUP;
          end
        end
      end
      EBT_ALEH: begin
        if (cnt == 4'h0) begin
          next_cnt = {2'b00, aleWidth};
          next_state = EBT_ALEL;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      EBT_ALEL: begin
        if (cnt == 4'h0) begin
          if (setupCode == 2'b00) begin
            next_cnt = widthCode;
            next_state = EBT_STROBE;
          end else begin
            next_cnt = {2'b00, setupCode} - 4'h1;
            next_state = EBT_SETUP;
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      EBT_SETUP: begin
        if (cnt == 4'h0) begin
          next_cnt = widthCode;
          next_state = EBT_STROBE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      EBT_STROBE: begin
        if (cnt == 4'h0) begin
          if (!isWrite) begin
            next_rdata = p5In;
          end
          if (holdCode == 2'b00) begin
            next_cnt = `EBT_OVERHEAD_CYCLES - 4'h1;
            next_state = EBT_TAIL;
          end else begin
            next_cnt = {2'b00, holdCode} - 4'h1;
            next_state = EBT_HOLD;
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      EBT_HOLD: begin
        if (cnt == 4'h0) begin
          next_cnt = `EBT_OVERHEAD_CYCLES - 4'h1;
          next_state = EBT_TAIL;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      EBT_TAIL: begin
        if (cnt == 4'h0) begin
          next_done = 1'b1;
          next_state = EBT_IDLE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      default: begin
        next_state = EBT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= EBT_IDLE;
      cnt <= 4'h0;
      muxed <= 1'b0;
      isWrite <= 1'b0;
      drvHigh <= 1'b0;
      addr <= 16'h0000;
      wdata <= 8'h00;
      rdata <= 8'h00;
      done <= 1'b0;
    end else if (clkEn) begin
      state <= next_state;
      cnt <= next_cnt;
      muxed <= next_muxed;
      isWrite <= next_isWrite;
      drvHigh <= next_drvHigh;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      done <= next_done;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  logic active, dataPhase;
  assign active = state inside {EBT_ALEH, EBT_ALEL, EBT_SETUP, EBT_STROBE, EBT_HOLD};
  assign dataPhase = state inside {EBT_SETUP, EBT_STROBE, EBT_HOLD};
  assign xferBusy = (state != EBT_IDLE);
  assign xferDone = done;
  assign xferRdata = rdata;
  assign ale = (state == EBT_ALEH);
  assign rdN = !((state == EBT_STROBE) && !isWrite);
  assign wrN = !((state == EBT_STROBE) && isWrite);

  always_comb begin
    p3Out = 8'h00;
    p3OeN = 1'b1;
    p4Out = 8'h00;
    p4OeN = 1'b1;
    p5Out = 8'h00;
    p5OeN = 1'b1;
    if (active && muxed) begin
      p4Out = addr[15:8];
      p4OeN = !drvHigh;
      if (state == EBT_ALEH || state == EBT_ALEL) begin
        p5Out = addr[7:0];
        p5OeN = 1'b0;
      end else if (isWrite) begin
        p5Out = wdata;
        p5OeN = 1'b0;
      end
    end else if (active) begin
      p4Out = addr[7:0];
      p4OeN = 1'b0;
      p3Out = addr[15:8];
      p3OeN = !drvHigh;
      if (isWrite && dataPhase) begin
        p5Out = wdata;
        p5OeN = 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // length of the current strobe pulse
  logic [4:0] strobeRun, next_strobeRun;

  always_comb begin
    next_strobeRun = strobeRun;
    if (!rdN || !wrN) begin
      next_strobeRun = strobeRun + 5'h01;
    end else begin
      next_strobeRun = 5'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobeRun <= 5'h00;
    end else if (clkEn) begin
      strobeRun <= next_strobeRun;
    end
  end

  sequence s_strobeEnd;
    $rose(rdN && wrN);
  endsequence

  chk_reset_value: assert property (@(posedge clk) $rose(rst) |=> timing == 8'hFF)
    else $error("timing register not all ones after reset");
  chk_ale_high: assert property (@(posedge clk) disable iff (rst)
    $rose(ale) && clkEn && aleWidth == 2'b00 |=> !ale)
    else $error("latch strobe high too long");
  chk_ale_low: assert property (@(posedge clk) disable iff (rst)
    state == EBT_ALEL |-> !ale && rdN && wrN)
    else $error("strobe during latch low phase");
  chk_strobe_width: assert property (@(posedge clk) disable iff (rst || !clkEn)
    s_strobeEnd |-> strobeRun == {1'b0, widthCode} + 5'h01)
    else $error("strobe width differs from programmed code");
  chk_data_during_wr: assert property (@(posedge clk) disable iff (rst)
    !wrN |-> !p5OeN && p5Out == wdata)
    else $error("write data not driven under strobe");
  chk_hold_data: assert property (@(posedge clk) disable iff (rst)
    $rose(wrN) && holdCode != 2'b00 |-> !p5OeN && p5Out == wdata)
    else $error("write data released before hold ends");
  chk_no_both: assert property (@(posedge clk) disable iff (rst)
    !(!rdN && !wrN))
    else $error("read and write strobes together");
  chk_upper_undriven: assert property (@(posedge clk) disable iff (rst)
    active && !muxed && !drvHigh |-> p3OeN)
    else $error("upper address driven without bank select");
  chk_muxed_ale: assert property (@(posedge clk) disable iff (rst)
    ale |-> muxed && p5Out == addr[7:0] && !p5OeN)
    else $error("latch strobe without low address on shared pins");
  chk_sfr_read: assert property (@(posedge clk) disable iff (rst)
    sfrHit |-> sfrRdata == timing)
    else $error("timing register read mismatch");
endmodule

/* tb/ebt_mem_model.sv */
`timescale 1ns/1ps
// ********
// external memory with address latch
// ********
module ebt_mem_model (
  // control
  input wire logic clk,
  input wire logic muxed,
  // pins
  input wire logic [7:0] p3Out,
  input wire logic p3OeN,
  input wire logic [7:0] p4Out,
  input wire logic p4OeN,
  input wire logic [7:0] p5Out,
  input wire logic p5OeN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic ale,
  output logic [7:0] p5In,
  // last write seen
  output logic [15:0] lastAddr,
  output logic [7:0] lastData,
  output logic lastHiOn
);
  logic [7:0] mem [256];
  logic [7:0] latched = 8'h00;
  logic [7:0] junk = 8'h5A;
  logic [7:0] lo;
  logic [7:0] hi;
  always_comb begin
    lo = muxed ? latched : (p4OeN ? junk : p4Out);
    hi = muxed ? p4Out : p3Out;
    p5In = rdN ? junk : mem[lo];
  end
  // released lines keep changing
  always @(posedge clk) begin
    junk <= ~junk;
    if (ale) latched <= p5Out;
    if (!wrN) begin
      mem[lo] <= p5OeN ? junk : p5Out;
      lastAddr <= {hi, lo};
      lastData <= p5OeN ? junk : p5Out;
      lastHiOn <= muxed ? !p4OeN : !p3OeN;
    end
  end
endmodule

/* tb/ebt_ext_bus_tb.sv */
`timescale 1ns/1ps
// ********
// bench
// ********
module ebt_ext_bus_tb;
  import ebt_pkg::*;
  logic clk = 1'h0, rst = 1'h1, clkEn = 1'h1, sfrWrite = 1'h0, xferReq = 1'h0;
  logic xferWrite = 1'h0, xferWide = 1'h0, sfrHit, xferBusy, xferDone, lastHiOn;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, bank = 8'hC3, xferWdata = 8'h00;
  logic [7:0] sfrRdata, xferRdata, p5In, p3Out, p4Out, p5Out, lastData, tmg;
  logic [3:0] sfrPage = 4'h0;
  logic [1:0] aleW = 2'h0;
  logic [15:0] xferAddr = 16'h0000, lastAddr;
  logic p3OeN, p4OeN, p5OeN, rdN, wrN, ale;
  ebt_mode_t muxSel = 3'h0;
  ebt_mode_t modes [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  logic [7:0] tmgs [6] = '{8'h00, 8'hFF, 8'h45, 8'h9A, 8'h7E, 8'hC1};
  int errCount = 0;
  int nChecks = 0;
  always #10 clk = ~clk;
  ebt_ext_bus ebt_ext_bus_inst (.clk, .rst, .clkEn, .sfrAddr, .sfrPage, .sfrWrite,
    .sfrWdata, .sfrRdata, .sfrHit, .bus_muxing_select(muxSel), .aleWidth(aleW),
    .upper_addr_bank(bank), .xferReq, .xferWrite, .xferWide, .xferAddr, .xferWdata,
    .xferBusy, .xferDone, .xferRdata, .p3Out, .p3OeN, .p4Out, .p4OeN, .p5In, .p5Out,
    .p5OeN, .rdN, .wrN, .ale);
  ebt_mem_model ebt_mem_model_inst (.clk, .muxed(!muxSel[2]), .p3Out, .p3OeN, .p4Out,
    .p4OeN, .p5Out, .p5OeN, .rdN, .wrN, .ale, .p5In, .lastAddr, .lastData, .lastHiOn);
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    nChecks++;
    if (g !== e) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] d);
    sfrAddr = a;
    sfrPage = pg;
    sfrWdata = d;
    sfrWrite = 1'h1;
    @(posedge clk);
    #1 sfrWrite = 1'h0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] e);
    sfrAddr = a;
    sfrPage = pg;
    #5 chk("timing reg", 16'(e), 16'(sfrRdata));
    chk("hit", 16'(a == 8'hEE && pg == 4'hF), 16'(sfrHit));
    @(posedge clk);
    #1;
  endtask
  // one transfer, phase lengths counted at the pins
  task automatic xfer(input logic w, input logic wd, input logic [15:0] ad,
                      input logic [7:0] d);
    int n, sw, ah, ex;
    logic on;
    n = 0;
    sw = 0;
    ah = 0;
    ex = tmg[7:6] + tmg[5:2] + 1 + tmg[1:0] + 4 + (muxSel[2] ? 0 : 2 * (aleW + 1));
    on = wd || muxSel == 3'h2 || muxSel == 3'h6;
    xferWrite = w;
    xferWide = wd;
    xferAddr = ad;
    xferWdata = d;
    xferReq = 1'h1;
    @(posedge clk);
    #1 xferReq = 1'h0;
    while (xferDone !== 1'h1 && n < 100) begin
      sw += (rdN === 1'h0 || wrN === 1'h0);
      ah += (ale === 1'h1);
      @(posedge clk);
      #1 n++;
    end
    chk("cycles", 16'(ex), 16'(n));
    chk("strobe", 16'(tmg[5:2] + 1), 16'(sw));
    chk("ale high", muxSel[2] ? 16'h0000 : 16'(aleW + 1), 16'(ah));
    if (w) begin
      chk("wdata", 16'(d), 16'(lastData));
      chk("lo addr", 16'(ad[7:0]), 16'(lastAddr[7:0]));
      chk("hi on", 16'(on), 16'(lastHiOn));
      if (on) chk("hi addr", 16'(wd ? ad[15:8] : bank), 16'(lastAddr[15:8]));
    end else chk("rdata", 16'(d), 16'(xferRdata));
  endtask
  task automatic finishTest;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    errCount++;
    finishTest();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'h0;
    reg_rd(8'hEE, 4'hF, 8'hFF);
    reg_rd(8'hEE, 4'hE, 8'h00);
    reg_wr(8'hED, 4'hF, 8'h12);
    reg_rd(8'hEE, 4'hF, 8'hFF);
    clkEn = 1'h0;
    reg_wr(8'hEE, 4'hF, 8'h00);
    reg_rd(8'hEE, 4'hF, 8'hFF);
    clkEn = 1'h1;
    $display("register test done");
    xferReq = 1'h1;
    for (int m = 0; m < 8; m += 4) begin
      muxSel = 3'(m);
      @(posedge clk);
      #1 chk("busy", 16'h0000, 16'(xferBusy));
    end
    xferReq = 1'h0;
    for (int i = 0; i < 6; i++) begin
      muxSel = modes[i];
      aleW = 2'(i * 3);
      tmg = tmgs[i];
      reg_wr(8'hEE, 4'hF, tmg);
      reg_rd(8'hEE, 4'hF, tmg);
      xfer(1'h1, 1'h1, 16'hA500 + 16'(i), 8'h3C ^ 8'(i));
      xfer(1'h0, 1'h1, 16'hA500 + 16'(i), 8'h3C ^ 8'(i));
      xfer(1'h1, 1'h0, 16'h5A80 + 16'(i), 8'hC3 ^ 8'(i));
      xfer(1'h0, 1'h0, 16'h5A80 + 16'(i), 8'hC3 ^ 8'(i));
      $display("mode %0d test done", muxSel);
    end
    rst = 1'h1;
    repeat (2) @(posedge clk);
    #1 rst = 1'h0;
    reg_rd(8'hEE, 4'hF, 8'hFF);
    $display("reset test done");
    finishTest();
  end
endmodule
